// >>> common/alm_pkg.sv
// shared constants, opcodes and decode types for the arithmetic, logic and move executor
package alm_pkg;

    // timing: oscillator periods per machine cycle, oscillator runs at the core clock
    localparam int OSC_PERIOD_PS = 4000;
    localparam int CLK_PERIOD_PS = 4000;
    localparam int MCYCLE_OSC = 12;
    localparam int MCYCLE_CLKS = (MCYCLE_OSC * OSC_PERIOD_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int LONG_OSC = 24;
    localparam int LONG_CLKS = (LONG_OSC * OSC_PERIOD_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

    // fetch schedule within one instruction
    localparam logic [7:0] CNT_OPCODE = 8'h01;
    localparam logic [7:0] CNT_REQ2 = 8'h02;
    localparam logic [7:0] CNT_BYTE1 = 8'h03;
    localparam logic [7:0] CNT_BYTE2 = 8'h04;

    // reset values
    localparam logic [15:0] PC_RESET = 16'h0000;
    localparam logic [7:0] ACC_RESET = 8'h00;

    // opcode group upper nibbles
    localparam logic [3:0] GRP_ADD = 4'h2;
    localparam logic [3:0] GRP_SUM_WITH_CARRY = 4'h3;
    localparam logic [3:0] GRP_SUBTRACT_WITH_BORROW = 4'h9;
    localparam logic [3:0] GRP_AND = 4'h5;
    localparam logic [3:0] GRP_OR = 4'h4;
    localparam logic [3:0] GRP_XOR = 4'h6;
    // operand-form lower nibbles
    localparam logic [3:0] LO_DIR_ACC = 4'h2;
    localparam logic [3:0] LO_DIR_IMM = 4'h3;
    localparam logic [3:0] LO_IMM = 4'h4;
    localparam logic [3:0] LO_DIR = 4'h5;
    // single opcodes
    localparam logic [7:0] OPC_RLC = 8'h33;
    localparam logic [7:0] OPC_RRC = 8'h13;
    localparam logic [7:0] OPC_SWAP = 8'hC4;
    localparam logic [7:0] OPC_MOV_A_IMM = 8'h74;
    localparam logic [7:0] OPC_MOV_A_DIR = 8'hE5;
    localparam logic [6:0] OPC_MOV_A_IND = 7'h73;
    localparam logic [4:0] OPC_MOV_A_REG = 5'h1D;
    localparam logic [4:0] OPC_MOV_REG_A = 5'h1F;
    localparam logic [4:0] OPC_MOV_REG_DIR = 5'h15;
    localparam logic [4:0] OPC_MOV_REG_IMM = 5'h0F;
    localparam logic [7:0] OPC_MOV_DIR_A = 8'hF5;
    localparam logic [4:0] OPC_MOV_DIR_REG = 5'h11;
    localparam logic [7:0] OPC_MOV_DIR_DIR = 8'h85;
    localparam logic [6:0] OPC_MOV_DIR_IND = 7'h43;

    typedef enum logic [3:0] {
        ALU_NOP, ALU_ADD, ALU_SUM_WITH_CARRY, ALU_SUBTRACT_WITH_BORROW, ALU_AND, ALU_OR, ALU_XOR,
        ALU_RLC, ALU_RRC, ALU_SWAP, ALU_COPY
    } alm_alu_t;

    typedef enum logic [2:0] {SRC_ACC, SRC_REG, SRC_DIR, SRC_IND, SRC_IMM, SRC_IMM2} alm_src_t;

    typedef enum logic [2:0] {DST_NONE, DST_ACC, DST_DIR, DST_DIR2, DST_REG} alm_dst_t;

    typedef struct packed {
        alm_alu_t alu;
        alm_src_t src;
        alm_dst_t dst;
        logic [1:0] len;
        logic long_op;
        logic known;
    } alm_dec_t;

endpackage

// >>> src/alm_exec.sv
// decode and timed execution of accumulator arithmetic, logic, rotate, swap and move opcodes
`timescale 1ns/1ps

// Summary of operation
// - sum adds operand to accumulator; 1 or 2 bytes; twelve periods
// - sum with carry adds operand plus carry; 1 or 2 bytes; twelve periods
// - subtract with borrow; 1 or 2 bytes; twelve periods
// - and into accumulator; 1 or 2 bytes; twelve periods
// - and accumulator into direct byte; two bytes; twelve periods
// - and constant into direct byte; three bytes; twenty-four periods
// - or into accumulator or direct byte from accumulator; twelve periods
// - or constant into direct byte; three bytes; twenty-four periods
// - xor into accumulator or direct byte; immediate-to-direct three bytes, 24
// - rotate left through carry; one byte; twelve periods
// - rotate right through carry; one byte; twelve periods
// - swap accumulator nibbles; one byte; twelve periods
// - copy register or indirect into accumulator; one byte; twelve periods
// - copy direct or immediate into accumulator; two bytes; twelve periods
// - copy into register: direct 2/24, accumulator 1/12, immediate 2/12
// - copy register into direct byte; two bytes; twenty-four periods
// - copy direct to direct; three bytes; twenty-four periods
// - copy indirect into direct byte; two bytes; twenty-four periods
// - copy accumulator into direct byte; two bytes; twelve periods
module alm_exec
    import alm_pkg::*;
#(
    parameter int IRAM_DEPTH = 128
)(
    input wire logic core_clk_i,         // core clock, one oscillator period
    input wire logic rst_n_i,            // synchronous reset, active low
    input wire logic [7:0] pm_data_i,    // program byte, valid the cycle after a read
    output logic [15:0] pm_addr_o,       // program memory byte address
    output logic pm_rd_o,                // program memory read strobe
    output logic [15:0] pc_o,            // address of the current instruction
    output logic [7:0] acc_o,            // accumulator
    output logic carry_o,                // carry flag
    output logic done_o,                 // one-cycle pulse after each instruction
    output logic unknown_o               // pulse: last opcode was not handled
);

    ////////////////////////////////////////////////////////////////////////////
    // decode

    function automatic alm_dec_t decode(input logic [7:0] op);
        alm_dec_t d;
        alm_alu_t grp;
        logic is_logic;
        d = '{alu: ALU_NOP, src: SRC_ACC, dst: DST_NONE, len: 2'd1, long_op: 1'b0, known: 1'b0};
        is_logic = 1'b0;
        case (op[7:4])
            GRP_ADD: grp = ALU_ADD;
            GRP_SUM_WITH_CARRY: grp = ALU_SUM_WITH_CARRY;
            GRP_SUBTRACT_WITH_BORROW: grp = ALU_SUBTRACT_WITH_BORROW;
            GRP_AND: grp = ALU_AND;
            GRP_OR: grp = ALU_OR;
            GRP_XOR: grp = ALU_XOR;
            default: grp = ALU_NOP;
        endcase
        is_logic = (grp == ALU_AND) || (grp == ALU_OR) || (grp == ALU_XOR);
        if (grp != ALU_NOP && op[3:0] >= LO_IMM)
        begin
            d.alu = grp;
            d.dst = DST_ACC;
            d.known = 1'b1;
            if (op[3:0] == LO_IMM)
            begin
                d.src = SRC_IMM;
                d.len = 2'd2;
            end
            else if (op[3:0] == LO_DIR)
            begin
                d.src = SRC_DIR;
                d.len = 2'd2;
            end
            else if (op[3])
                d.src = SRC_REG;
            else
                d.src = SRC_IND;
        end
        else if (is_logic && op[3:0] == LO_DIR_ACC)
        begin
            d = '{alu: grp, src: SRC_ACC, dst: DST_DIR, len: 2'd2, long_op: 1'b0, known: 1'b1};
        end
        else if (is_logic && op[3:0] == LO_DIR_IMM)
        begin
            d = '{alu: grp, src: SRC_IMM2, dst: DST_DIR, len: 2'd3, long_op: 1'b1, known: 1'b1};
        end
        else if (op == OPC_RLC)
            d = '{alu: ALU_RLC, src: SRC_ACC, dst: DST_ACC, len: 2'd1, long_op: 1'b0, known: 1'b1};
        else if (op == OPC_RRC)
            d = '{alu: ALU_RRC, src: SRC_ACC, dst: DST_ACC, len: 2'd1, long_op: 1'b0, known: 1'b1};
        else if (op == OPC_SWAP)
            d = '{alu: ALU_SWAP, src: SRC_ACC, dst: DST_ACC, len: 2'd1, long_op: 1'b0, known: 1'b1};
        else if (op == OPC_MOV_A_IMM)
            d = '{alu: ALU_COPY, src: SRC_IMM, dst: DST_ACC, len: 2'd2, long_op: 1'b0, known: 1'b1};
        else if (op == OPC_MOV_A_DIR)
            d = '{alu: ALU_COPY, src: SRC_DIR, dst: DST_ACC, len: 2'd2, long_op: 1'b0, known: 1'b1};
        else if (op[7:1] == OPC_MOV_A_IND)
            d = '{alu: ALU_COPY, src: SRC_IND, dst: DST_ACC, len: 2'd1, long_op: 1'b0, known: 1'b1};
        else if (op[7:3] == OPC_MOV_A_REG)
            d = '{alu: ALU_COPY, src: SRC_REG, dst: DST_ACC, len: 2'd1, long_op: 1'b0, known: 1'b1};
        else if (op[7:3] == OPC_MOV_REG_A)
            d = '{alu: ALU_COPY, src: SRC_ACC, dst: DST_REG, len: 2'd1, long_op: 1'b0, known: 1'b1};
        else if (op[7:3] == OPC_MOV_REG_DIR)
            d = '{alu: ALU_COPY, src: SRC_DIR, dst: DST_REG, len: 2'd2, long_op: 1'b1, known: 1'b1};
        else if (op[7:3] == OPC_MOV_REG_IMM)
            d = '{alu: ALU_COPY, src: SRC_IMM, dst: DST_REG, len: 2'd2, long_op: 1'b0, known: 1'b1};
        else if (op == OPC_MOV_DIR_A)
            d = '{alu: ALU_COPY, src: SRC_ACC, dst: DST_DIR, len: 2'd2, long_op: 1'b0, known: 1'b1};
        else if (op[7:3] == OPC_MOV_DIR_REG)
            d = '{alu: ALU_COPY, src: SRC_REG, dst: DST_DIR, len: 2'd2, long_op: 1'b1, known: 1'b1};
        else if (op == OPC_MOV_DIR_DIR)
            d = '{alu: ALU_COPY, src: SRC_DIR, dst: DST_DIR2, len: 2'd3, long_op: 1'b1, known: 1'b1};
        else if (op[7:1] == OPC_MOV_DIR_IND)
            d = '{alu: ALU_COPY, src: SRC_IND, dst: DST_DIR, len: 2'd2, long_op: 1'b1, known: 1'b1};
        return d;
    endfunction

    // direct and indirect addresses wrap into the on-chip array; no special registers here
    function automatic logic [6:0] ram_idx(input logic [7:0] a);
        return a[6:0];
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // state

    logic [7:0] iram [IRAM_DEPTH];
    logic [15:0] pc_q, pc_d;
    logic [15:0] addr_q, addr_d;
    logic rd_q, rd_d;
    logic [7:0] acc_q, acc_d;
    logic carry_q, carry_d;
    logic [7:0] cnt_q, cnt_d;
    logic [7:0] op_q, b1_q, b2_q;
    alm_dec_t dec_q;
    logic done_q, unk_q;

    wire alm_dec_t dec_now = decode(pm_data_i);
    wire logic at_opcode = (cnt_q == CNT_OPCODE);
    wire alm_dec_t dec = at_opcode ? dec_now : dec_q;
    wire logic [7:0] last_cnt = dec_q.long_op ? 8'(LONG_CLKS - 1) : 8'(MCYCLE_CLKS - 1);
    wire logic exec = (cnt_q == last_cnt) && (cnt_q > CNT_BYTE2);
    wire logic [15:0] pc_next = pc_q + {14'h0000, dec_q.len};

    ////////////////////////////////////////////////////////////////////////////
    // operand selection and result

    wire logic [7:0] reg_val = iram[{4'h0, op_q[2:0]}];
    wire logic [7:0] ptr_val = iram[{6'h00, op_q[0]}];
    logic [7:0] src_val;
    logic [6:0] dst_idx;
    logic [7:0] res;
    logic res_c;

    always_comb
    begin
        case (dec_q.src)
            SRC_REG: src_val = reg_val;
            SRC_DIR: src_val = iram[ram_idx(b1_q)];
            SRC_IND: src_val = iram[ram_idx(ptr_val)];
            SRC_IMM: src_val = b1_q;
            SRC_IMM2: src_val = b2_q;
            default: src_val = acc_q;
        endcase
    end

    always_comb
    begin
        case (dec_q.dst)
            DST_REG: dst_idx = {4'h0, op_q[2:0]};
            DST_DIR2: dst_idx = ram_idx(b2_q);
            default: dst_idx = ram_idx(b1_q);
        endcase
    end

    wire logic [7:0] dst_val = (dec_q.dst == DST_ACC) ? acc_q : iram[dst_idx];
    wire logic [8:0] sum9 = {1'b0, dst_val} + {1'b0, src_val}
        + {8'h00, (dec_q.alu == ALU_SUM_WITH_CARRY) && carry_q};
    wire logic [8:0] diff9 = {1'b0, dst_val} - {1'b0, src_val} - {8'h00, carry_q};

    always_comb
    begin
        res = dst_val;
        res_c = carry_q;
        case (dec_q.alu)
            ALU_ADD, ALU_SUM_WITH_CARRY:
            begin
                res = sum9[7:0];
                res_c = sum9[8];
            end
            ALU_SUBTRACT_WITH_BORROW:
            begin
                res = diff9[7:0];
                res_c = diff9[8];
            end
            ALU_AND: res = dst_val & src_val;
            ALU_OR: res = dst_val | src_val;
            ALU_XOR: res = dst_val ^ src_val;
            ALU_RLC:
            begin
                res = {acc_q[6:0], carry_q};
                res_c = acc_q[7];
            end
            ALU_RRC:
            begin
                res = {carry_q, acc_q[7:1]};
                res_c = acc_q[0];
            end
            ALU_SWAP: res = {acc_q[3:0], acc_q[7:4]};
            ALU_COPY: res = src_val;
            default: res = dst_val;
        endcase
    end

    wire logic acc_we = exec && (dec_q.dst == DST_ACC);
    wire logic ram_we = exec && (dec_q.dst != DST_ACC) && (dec_q.dst != DST_NONE);

    ////////////////////////////////////////////////////////////////////////////
    // sequencing: opcode read at count 0, operand reads follow back to back

    assign cnt_d = exec ? 8'h00 : cnt_q + 8'h01;
    assign pc_d = exec ? pc_next : pc_q;
    assign acc_d = acc_we ? res : acc_q;
    assign carry_d = exec ? res_c : carry_q;
    assign rd_d = exec || (at_opcode && dec.len > 2'd1)
        || ((cnt_q == CNT_REQ2) && dec.len == 2'd3);
    assign addr_d = exec ? pc_next : (rd_d ? addr_q + 16'h0001 : addr_q);

    always_ff @(posedge core_clk_i)
    begin
        if (!rst_n_i)
        begin
            pc_q <= PC_RESET;
            addr_q <= PC_RESET;
            rd_q <= 1'b1;
            acc_q <= ACC_RESET;
            carry_q <= 1'b0;
            cnt_q <= 8'h00;
            op_q <= 8'h00;
            b1_q <= 8'h00;
            b2_q <= 8'h00;
            dec_q <= '{alu: ALU_NOP, src: SRC_ACC, dst: DST_NONE, len: 2'd1, long_op: 1'b0,
                       known: 1'b0};
            done_q <= 1'b0;
            unk_q <= 1'b0;
        end
        else
        begin
            pc_q <= pc_d;
            addr_q <= addr_d;
            rd_q <= rd_d;
            acc_q <= acc_d;
            carry_q <= carry_d;
            cnt_q <= cnt_d;
            op_q <= at_opcode ? pm_data_i : op_q;
            b1_q <= (cnt_q == CNT_BYTE1) ? pm_data_i : b1_q;
            b2_q <= (cnt_q == CNT_BYTE2) ? pm_data_i : b2_q;
            dec_q <= dec;
            done_q <= exec;
            unk_q <= exec && !dec_q.known;
        end
    end

    // data memory carries no reset, like ordinary on-chip memory
    always_ff @(posedge core_clk_i)
    begin
        if (ram_we)
            iram[dst_idx] <= res;
    end

    assign pm_addr_o = addr_q;
    assign pm_rd_o = rd_q;
    assign pc_o = pc_q;
    assign acc_o = acc_q;
    assign carry_o = carry_q;
    assign done_o = done_q;
    assign unknown_o = unk_q;

    ////////////////////////////////////////////////////////////////////////////
    // checks

    logic [7:0] gap_q;
    always_ff @(posedge core_clk_i)
    begin
        if (!rst_n_i)
            gap_q <= 8'h00;
        else
            gap_q <= done_q ? 8'h01 : gap_q + 8'h01;
    end

    property p_add_imm;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        exec && op_q == {GRP_ADD, LO_IMM} |=> acc_q == $past(acc_q) + $past(b1_q)
            && pc_q == $past(pc_q) + 16'h0002;
    endproperty
    a_add_imm: assert property (p_add_imm) else $error("add immediate wrong");

    property p_sum_with_carry_gap;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        exec && op_q[7:4] == GRP_SUM_WITH_CARRY && dec_q.known |=> gap_q == 8'(MCYCLE_CLKS);
    endproperty
    a_sum_with_carry_gap: assert property (p_sum_with_carry_gap) else $error("add with carry timing");

    property p_subtract_with_borrow;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        exec && dec_q.alu == ALU_SUBTRACT_WITH_BORROW |=>
            acc_q == $past(acc_q) - $past(src_val) - $past(carry_q)
            && carry_q == ({1'b0, $past(acc_q)} < {1'b0, $past(src_val)} + {8'h00, $past(carry_q)});
    endproperty
    a_subtract_with_borrow: assert property (p_subtract_with_borrow) else $error("borrow not stored");

    property p_and_dir_imm;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        done_q && dec_q.alu == ALU_AND && dec_q.src == SRC_IMM2 |->
            gap_q == 8'(LONG_CLKS) && pc_q == $past(pc_q, LONG_CLKS) + 16'h0003;
    endproperty
    a_and_dir_imm: assert property (p_and_dir_imm) else $error("and const timing");

    property p_rlc;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        exec && dec_q.alu == ALU_RLC |=>
            acc_q == {$past(acc_q[6:0]), $past(carry_q)} && carry_q == $past(acc_q[7]);
    endproperty
    a_rlc: assert property (p_rlc) else $error("rotate left wrong");

    property p_rrc;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        exec && dec_q.alu == ALU_RRC |=>
            acc_q == {$past(carry_q), $past(acc_q[7:1])} && carry_q == $past(acc_q[0]);
    endproperty
    a_rrc: assert property (p_rrc) else $error("rotate right wrong");

    property p_swap;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        exec && dec_q.alu == ALU_SWAP |=> acc_q == {$past(acc_q[3:0]), $past(acc_q[7:4])};
    endproperty
    a_swap: assert property (p_swap) else $error("swap wrong");

    property p_mov_dir_acc;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        exec && op_q == OPC_MOV_DIR_A |=> iram[ram_idx(b1_q)] == $past(acc_q)
            && pc_q == $past(pc_q) + 16'h0002;
    endproperty
    a_mov_dir_acc: assert property (p_mov_dir_acc) else $error("store acc wrong");

    property p_gap;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        done_q |-> gap_q == 8'(MCYCLE_CLKS) || gap_q == 8'(LONG_CLKS);
    endproperty
    a_gap: assert property (p_gap) else $error("instruction length in cycles");

    property p_fetch_seq;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        rd_q && cnt_q == CNT_REQ2 |-> pm_addr_o == pc_q + 16'h0001;
    endproperty
    a_fetch_seq: assert property (p_fetch_seq) else $error("operand fetch address");

    c_long: cover property (@(posedge core_clk_i) disable iff (!rst_n_i)
        done_q && dec_q.long_op);
    c_dir_dir: cover property (@(posedge core_clk_i) disable iff (!rst_n_i)
        exec && op_q == OPC_MOV_DIR_DIR);
    c_carry_out: cover property (@(posedge core_clk_i) disable iff (!rst_n_i)
        exec && dec_q.alu == ALU_SUM_WITH_CARRY && sum9[8]);

endmodule

// >>> tb/alm_prog_mem.sv
// program memory model: answers each read strobe with the addressed byte one cycle later
`timescale 1ns/1ps
module alm_prog_mem (
    input wire logic core_clk_i,        // core clock
    input wire logic [15:0] pm_addr_i,  // byte address
    input wire logic pm_rd_i,           // read strobe
    output logic [7:0] pm_data_o        // read data
);
    logic [7:0] mem [0:4095];
    logic [7:0] data_q = 8'h00;

    assign pm_data_o = data_q;

    // outside answer cycles the bus toggles so a stale byte is never mistaken for data
    always @(posedge core_clk_i)
    begin
        if (pm_rd_i)
            data_q <= mem[pm_addr_i[11:0]];
        else
            data_q <= ~data_q;
    end
endmodule

// >>> tb/test_cpu_arith_logic_move_exec.sv
// self-checking bench: integer model of the executor compared at every completed instruction
`timescale 1ns/1ps
module test_cpu_arith_logic_move_exec
    import alm_pkg::*;
;
    typedef struct packed {
        logic [15:0] pc;
        logic [15:0] cyc;
        logic unk;
        logic cy;
        logic [7:0] acc;
    } alm_tb_exp_t;

    logic core_clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [7:0] pm_data_i;
    logic [15:0] pm_addr_o;
    logic [15:0] pc_o;
    logic pm_rd_o;
    logic carry_o;
    logic done_o;
    logic unknown_o;
    logic [7:0] acc_o;
    int n_fail = 0;
    int n_compared = 0;
    int seed = 32'h2573;
    int iram [128];
    int acc = 0;
    int cy = 0;
    int pc = 0;
    int total = 0;
    alm_tb_exp_t exp_q [$];

    initial
    begin
        forever #2 core_clk_i = ~core_clk_i;
    end

    alm_exec u_dut (
        .core_clk_i(core_clk_i),
        .rst_n_i(rst_n_i),
        .pm_data_i(pm_data_i),
        .pm_addr_o(pm_addr_o),
        .pm_rd_o(pm_rd_o),
        .pc_o(pc_o),
        .acc_o(acc_o),
        .carry_o(carry_o),
        .done_o(done_o),
        .unknown_o(unknown_o)
    );

    alm_prog_mem u_mem (
        .core_clk_i(core_clk_i),
        .pm_addr_i(pm_addr_o),
        .pm_rd_i(pm_rd_o),
        .pm_data_o(pm_data_i)
    );

    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [15:0] seen, input logic [15:0] expd);
        n_compared++;
        if (seen !== expd)
        begin
            n_fail++;
            $display("MISMATCH at %0t: saw %h expected %h", $time, seen, expd);
        end
    endtask

    task automatic final_report();
        $display("compared %0d, mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // places one instruction in program memory and runs it on the reference model
    task automatic ins(input int op, input int b1, input int b2);
        int hi, lo, v, r, d, len, cyc;
        alm_tb_exp_t x;
        hi = op >> 4;
        lo = op & 15;
        d = b1 & 127;
        len = 2;
        cyc = MCYCLE_CLKS;
        x.unk = 1'b0;
        v = (lo == 4) ? b1 : (lo == 5) ? iram[d]
            : (lo < 8) ? iram[iram[lo & 1] & 127] : iram[lo & 7];
        if (op == 8'h33 || op == 8'h13 || op == 8'hC4)
        begin
            len = 1;
            r = (op == 8'h33) ? (acc << 1) | cy : (op == 8'h13) ? (acc >> 1) | (cy << 7)
                : (acc << 4) | (acc >> 4);
            if (op != 8'hC4)
                cy = (op == 8'h33) ? acc >> 7 : acc & 1;
            acc = r & 255;
        end
        else if (hi inside {2, 3, 9, 4, 5, 6} && lo >= 4)
        begin
            len = (lo < 6) ? 2 : 1;
            r = (hi == 2) ? acc + v : (hi == 3) ? acc + v + cy : (hi == 9) ? acc - v - cy
                : (hi == 5) ? acc & v : (hi == 4) ? acc | v : acc ^ v;
            if (hi inside {2, 3, 9})
                cy = (r >> 8) & 1;
            acc = r & 255;
        end
        else if (hi inside {4, 5, 6} && lo inside {2, 3})
        begin
            len = lo;
            cyc = (lo == 3) ? LONG_CLKS : MCYCLE_CLKS;
            v = (lo == 2) ? acc : b2;
            iram[d] = (hi == 5) ? iram[d] & v : (hi == 4) ? iram[d] | v : iram[d] ^ v;
        end
        else if (op inside {8'h74, [8'hE5:8'hEF]})
        begin
            len = (lo < 6) ? 2 : 1;
            acc = v;
        end
        else if (op == 8'hF5 || op >= 8'hF8)
        begin
            len = (lo == 5) ? 2 : 1;
            iram[(lo == 5) ? d : lo & 7] = acc;
        end
        else if (op inside {[8'h78:8'h7F]})
            iram[lo & 7] = b1;
        else if (op inside {[8'hA8:8'hAF], [8'h85:8'h8F]})
        begin
            cyc = LONG_CLKS;
            len = (op == 8'h85) ? 3 : 2;
            if (hi == 10)
                iram[lo & 7] = iram[d];
            else if (lo >= 8)
                iram[d] = iram[lo & 7];
            else if (lo == 5)
                iram[b2 & 127] = iram[d];
            else
                iram[d] = v;
        end
        else
        begin
            len = 1;
            x.unk = 1'b1;
        end
        u_mem.mem[pc] = op[7:0];
        u_mem.mem[pc + 1] = b1[7:0];
        u_mem.mem[pc + 2] = b2[7:0];
        pc += len;
        total += cyc;
        x.pc = pc[15:0];
        x.cyc = cyc[15:0];
        x.cy = cy[0];
        x.acc = acc[7:0];
        exp_q.push_back(x);
    endtask

    task automatic verify(input alm_tb_exp_t x, input int n);
        check(16'(n), x.cyc);
        check(pm_addr_o, x.pc);
        check(16'(pm_rd_o), 16'h0001);
        check(16'(acc_o), 16'(x.acc));
        check(16'(carry_o), 16'(x.cy));
        check(pc_o, x.pc);
        check(16'(unknown_o), 16'(x.unk));
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        int n;
        for (int a = 0; a < 4096; a++)
            u_mem.mem[a] = 8'hA5;
        // data memory is not reset, so every byte is written before any read
        for (int a = 0; a < 128; a++)
        begin
            ins(8'h74, $random(seed) & 255, 0);
            ins(8'hF5, a, 0);
        end
        // every opcode twice; forms the rules leave open are skipped
        repeat (2)
            for (int op = 0; op < 256; op++)
                if (!(op inside {8'h22, 8'h23, 8'h32, 8'h92, 8'h93}))
                    ins(op, $random(seed) & 255, $random(seed) & 255);
        repeat (16) @(negedge core_clk_i);
        rst_n_i = 1'b1;
        foreach (exp_q[i])
        begin
            n = 0;
            do
            begin
                @(negedge core_clk_i);
                n++;
            end
            while (done_o !== 1'b1 && n < 40);
            verify(exp_q[i], n);
        end
        final_report();
    end

    initial
    begin
        wait (rst_n_i === 1'b1);
        repeat (2 * total + 400) @(posedge core_clk_i);
        n_fail++;
        $display("MISMATCH at %0t: run did not complete", $time);
        final_report();
    end
endmodule
